// >>> logic/mbsp_top.sv
// Module: multibuffered serial port with transfer groups and trigger select
// Function
// [RULE1] Each word shifts in and out with a length of 2 to 16 bits at the programmed rate.
// [RULE2] The bit rate comes from an 11-bit baud divider.
// [RULE3] Master mode drives the serial clock; slave mode follows the far party's clock.
// [RULE4] Every word carries its own format taken from its buffer control field.
// [RULE5] Serial pins not in use work as plain software inputs and outputs.
// [RULE6] The buffer memory holds 128 entries.
// [RULE7] Each entry has 16-bit transmit, receive, control and status parts.
// [RULE8] Software splits the buffers into groups of consecutive entries.
// [RULE9] Each group has its own trigger source and event type.
// [RULE10] Event types include rising edge and sustained low level.
// [RULE11] Fifteen trigger sources are open to every group.
// [RULE12] Source code 0 is none, 1-8 port A pins, 9-14 timer channels, 15 the tick counter.
// [RULE13] Timer channel triggers come straight from the timer, ahead of the pads.
// [RULE14] Port A triggers come from the pad inputs, so driven or external levels count.
// [RULE15] Each source is sampled on this clock and edges found by comparing two samples.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mbsp_top (
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   // Trigger sources
   input  wire logic [7:0]           general_io_port_a,
   input  wire logic [5:0]           high_end_timer_channel,
   input  wire logic                 tick_count,
   // Serial pins
   input  wire mbsp_pkg::mbsp_pins_s pin_level,
   output mbsp_pkg::mbsp_pins_s      pin_drive,
   output mbsp_pkg::mbsp_pins_s      pin_oe
);
   import mbsp_pkg::*;

   // Bus state
   logic              ap_ff;
   logic              wr_ff;
   logic              rdw_ff;
   logic [11:0]       adr_ff;
   logic [31:0]       hrdata_ff;
   // Software registers
   logic [1:0]        ctrl_ff;
   logic [BAUD_W-1:0] baud_ff;
   logic [3:0]        pfun_ff;
   logic [3:0]        gdir_ff;
   logic [3:0]        gout_ff;
   mbsp_tg_s          tg_ff [NGRP];
   // Buffer memory
   logic [WORD_W-1:0] tx_mem [NBUF];
   logic [WORD_W-1:0] cw_mem [NBUF];
   logic [WORD_W-1:0] rx_mem [NBUF];
   logic [WORD_W-1:0] st_mem [NBUF];
   // Triggers
   logic [NGRP-1:0]   prev_ff;
   logic [NGRP-1:0]   pend_ff;
   logic [NGRP-1:0]   sel_v;
   logic [NGRP-1:0]   hit_v;
   logic [NGRP-1:0]   clr_v;
   logic [7:0]        gio_s;
   mbsp_pins_s        pin_s;
   // Sequencer
   mbsp_seq_e         state_ff;
   mbsp_seq_e         nxt_state;
   logic [2:0]        grp_ff;
   logic [6:0]        ptr_ff;
   logic [2:0]        pick;
   logic              launch;
   mbsp_tg_s          tg_cur;
   // Engine
   mbsp_fmt_s         eng_fmt;
   logic [WORD_W-1:0] eng_rxd;
   logic              eng_busy;
   logic              eng_done;
   logic              eng_sclk;
   logic              eng_sdo;
   logic              run_ok;
   logic              mst;
   // Decode
   logic              take;
   logic              we;
   logic              rd_st;
   logic              is_ram;
   logic              is_tg;
   logic [6:0]        bix;
   logic [2:0]        gix;
   logic [31:0]       tg_rd;
   logic [31:0]       reg_rd;
   logic [31:0]       stat_rd;
   mbsp_tg_s          tg_wr;
   // Pins
   mbsp_pins_s        ser_drv;
   mbsp_pins_s        ser_oe;
   logic [WORD_W-1:0] st_word;

   // Address phase and decode
   assign take    = hsel & htrans[1] & hready;
   assign we      = ap_ff & wr_ff;
   assign rd_st   = ap_ff & ~wr_ff & ~rdw_ff;
   assign is_ram  = adr_ff[10];
   assign is_tg   = adr_ff[11:5] == OFS_TG[11:5];
   assign bix     = adr_ff[9:3];
   assign gix     = adr_ff[4:2];

   assign hreadyout = ~rd_st;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_ff     <= 1'b0;
         wr_ff     <= 1'b0;
         rdw_ff    <= 1'b0;
         adr_ff    <= 12'h000;
         hrdata_ff <= 32'h0000_0000;
      end else begin
         if (hready)
            ap_ff <= take;
         if (take) begin
            wr_ff  <= hwrite;
            adr_ff <= haddr[11:0];
         end
         rdw_ff <= rd_st;
         if (rd_st)
            hrdata_ff <= reg_rd;
      end
   end

   // Read selection
   assign tg_cur  = tg_ff[grp_ff];
   assign tg_rd   = 32'(tg_ff[gix].src) | (32'(tg_ff[gix].evt) << TG_EVT)
                  | (32'(tg_ff[gix].ena) << TG_ENA) | (32'(tg_ff[gix].beg) << TG_BEG)
                  | (32'(tg_ff[gix].fin) << TG_FIN);
   assign stat_rd = 32'({state_ff != SQ_IDLE, grp_ff, ptr_ff, pend_ff});
   assign reg_rd  = is_ram ? (adr_ff[2] ? {st_mem[bix], rx_mem[bix]}
                                        : {cw_mem[bix], tx_mem[bix]})
                  : is_tg                ? tg_rd
                  : (adr_ff == OFS_CTRL) ? 32'(ctrl_ff)
                  : (adr_ff == OFS_BAUD) ? 32'(baud_ff)
                  : (adr_ff == OFS_PFUN) ? 32'(pfun_ff)
                  : (adr_ff == OFS_GDIR) ? 32'(gdir_ff)
                  : (adr_ff == OFS_GOUT) ? 32'(gout_ff)
                  : (adr_ff == OFS_GIN)  ? 32'(pin_s)
                  : (adr_ff == OFS_STAT) ? stat_rd
                  : 32'h0000_0000;

   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= CTRL_RST;
         baud_ff <= BAUD_RST;
         pfun_ff <= PIN_RST;
         gdir_ff <= PIN_RST;
         gout_ff <= PIN_RST;
      end else if (we && !is_ram) begin
         if (adr_ff == OFS_CTRL)
            ctrl_ff <= hwdata[1:0];
         if (adr_ff == OFS_BAUD)
            baud_ff <= hwdata[BAUD_W-1:0]; // RULE2
         if (adr_ff == OFS_PFUN)
            pfun_ff <= hwdata[3:0]; // RULE5
         if (adr_ff == OFS_GDIR)
            gdir_ff <= hwdata[3:0]; // RULE5
         if (adr_ff == OFS_GOUT)
            gout_ff <= hwdata[3:0]; // RULE5
      end
   end

   // Buffer memory, 128 entries of four half-words
   assign st_word = {11'h000, ~mst, grp_ff, 1'b1};

   always_ff @(posedge hclk) begin
      if (we && is_ram && !adr_ff[2]) begin
         tx_mem[bix] <= hwdata[15:0]; // RULE6 RULE7
         cw_mem[bix] <= hwdata[31:16]; // RULE7
      end
      if (state_ff == SQ_STORE) begin
         rx_mem[ptr_ff] <= eng_rxd; // RULE7
         st_mem[ptr_ff] <= st_word; // RULE7
      end
   end

   // Port A and pin inputs pass the synchroniser
   mbsp_sync #(
      .W   (12),
      .RST (SYNC_RST)
   ) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({pin_level, general_io_port_a}), // RULE14
      .q       ({pin_s, gio_s})
   );

   // Group trigger selection
   assign tg_wr = '{fin: hwdata[TG_FIN +: 7],
                    beg: hwdata[TG_BEG +: 7],
                    ena: hwdata[TG_ENA],
                    evt: mbsp_evt_e'(hwdata[TG_EVT +: 2]),
                    src: hwdata[TG_SRC +: 4]};

   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      // Timer and tick run on this clock already
      assign sel_v[g] = trig_pick(tg_ff[g].src, gio_s, high_end_timer_channel, tick_count); // RULE11 RULE12 RULE13
      assign hit_v[g] = tg_ff[g].ena & (tg_ff[g].src != SRC_NONE)
                      & evt_hit(tg_ff[g].evt, sel_v[g], prev_ff[g]); // RULE10 RULE15

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            tg_ff[g]   <= '0;
            prev_ff[g] <= 1'b0;
            pend_ff[g] <= 1'b0;
         end else begin
            if (we && is_tg && gix == 3'(g))
               tg_ff[g] <= tg_wr; // RULE8 RULE9
            prev_ff[g] <= sel_v[g]; // RULE15
            pend_ff[g] <= hit_v[g] | (pend_ff[g] & ~clr_v[g]);
         end
      end
   end

   // Group sequencer
   assign run_ok = ctrl_ff[CTRL_EN];
   assign mst    = ctrl_ff[CTRL_MST];
   assign pick   = first_set(pend_ff);
   assign launch = (state_ff == SQ_IDLE) && (nxt_state == SQ_LOAD);
   assign clr_v  = launch ? (NGRP'(1) << pick) : '0;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SQ_IDLE:  if (run_ok && |pend_ff) nxt_state = SQ_LOAD;
         SQ_LOAD:  nxt_state = SQ_SHIFT;
         SQ_SHIFT: if (eng_done) nxt_state = SQ_STORE;
         SQ_STORE: nxt_state = (ptr_ff == tg_cur.fin || !run_ok) ? SQ_IDLE : SQ_LOAD; // RULE8
         default:  nxt_state = SQ_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= SQ_IDLE;
         grp_ff   <= 3'h0;
         ptr_ff   <= 7'h00;
      end else begin
         state_ff <= nxt_state;
         if (launch) begin
            grp_ff <= pick;
            ptr_ff <= tg_ff[pick].beg; // RULE8
         end else if (state_ff == SQ_STORE) begin
            ptr_ff <= ptr_ff + 1'b1;
         end
      end
   end

   // Shift engine
   assign eng_fmt = '{cpol: cw_mem[ptr_ff][CW_POL], len_m1: cw_mem[ptr_ff][CW_LEN +: 4]}; // RULE4

   mbsp_shift u_shift (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .start    (state_ff == SQ_LOAD),
      .master   (mst),
      .baud     (baud_ff),
      .fmt      (eng_fmt),
      .txd      (tx_mem[ptr_ff]),
      .busy     (eng_busy),
      .done     (eng_done),
      .rxd      (eng_rxd),
      .sclk_in  (pin_s.sclk),
      .sdat_in  (mst ? pin_s.miso : pin_s.mosi),
      .sel_n_in (pin_s.cs_n),
      .sclk_out (eng_sclk),
      .sdat_out (eng_sdo)
   );

   // Pin function and direction
   assign ser_drv = '{sclk: eng_sclk, mosi: eng_sdo, miso: eng_sdo, cs_n: ~eng_busy};
   assign ser_oe  = mst ? '{sclk: run_ok, mosi: run_ok, miso: 1'b0, cs_n: run_ok}
                        : '{sclk: 1'b0, mosi: 1'b0, miso: run_ok & ~pin_s.cs_n, cs_n: 1'b0}; // RULE3
   assign pin_drive = mbsp_pins_s'((pfun_ff & ser_drv) | (~pfun_ff & gout_ff)); // RULE5
   assign pin_oe    = mbsp_pins_s'((pfun_ff & ser_oe) | (~pfun_ff & gdir_ff)); // RULE5

   property p_gpio;
      @(posedge hclk) disable iff (!hresetn)
      we && !is_ram && adr_ff == OFS_GOUT && pfun_ff == 4'h0 |=> pin_drive == $past(hwdata[3:0]);
   endproperty
   a_gpio: assert property (p_gpio) else $error("Pin did not follow software output"); // RULE5

   property p_low;
      @(posedge hclk) disable iff (!hresetn)
      tg_ff[0].ena && tg_ff[0].src != SRC_NONE && tg_ff[0].evt == EVT_LOW && !sel_v[0] |=> pend_ff[0];
   endproperty
   a_low: assert property (p_low) else $error("Low level did not trigger"); // RULE10

   property p_rise;
      @(posedge hclk) disable iff (!hresetn)
      tg_ff[0].ena && tg_ff[0].src != SRC_NONE && tg_ff[0].evt == EVT_RISE
         && $rose(sel_v[0]) |=> pend_ff[0];
   endproperty
   a_rise: assert property (p_rise) else $error("Rising edge did not trigger"); // RULE15

   property p_tmr;
      @(posedge hclk) disable iff (!hresetn)
      tg_ff[0].src == SRC_TMR0 |-> sel_v[0] == high_end_timer_channel[0];
   endproperty
   a_tmr: assert property (p_tmr) else $error("Timer source decode wrong"); // RULE12

   property p_end;
      @(posedge hclk) disable iff (!hresetn)
      state_ff == SQ_STORE && ptr_ff == tg_cur.fin |=> state_ff == SQ_IDLE ##1 !eng_busy;
   endproperty
   a_end: assert property (p_end) else $error("Group ran past its last buffer"); // RULE8

   property p_store;
      @(posedge hclk) disable iff (!hresetn)
      state_ff == SQ_STORE |=> rx_mem[$past(ptr_ff)] == $past(eng_rxd);
   endproperty
   a_store: assert property (p_store) else $error("Receive half-word not stored"); // RULE7
endmodule
`default_nettype wire

// >>> logic/mbsp_pkg.sv
// Package: constants, types and helpers of the multibuffered serial port
package mbsp_pkg;
   // Sizes
   localparam int NBUF   = 128;
   localparam int NGRP   = 8;
   localparam int BAUD_W = 11;
   localparam int WORD_W = 16;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_BAUD = 12'h004;
   localparam logic [11:0] OFS_PFUN = 12'h008;
   localparam logic [11:0] OFS_GDIR = 12'h00C;
   localparam logic [11:0] OFS_GOUT = 12'h010;
   localparam logic [11:0] OFS_GIN  = 12'h014;
   localparam logic [11:0] OFS_STAT = 12'h018;
   localparam logic [11:0] OFS_TG   = 12'h020;
   localparam logic [11:0] OFS_RAM  = 12'h400;
   // Field positions
   localparam int CTRL_EN  = 0;
   localparam int CTRL_MST = 1;
   localparam int TG_SRC   = 0;
   localparam int TG_EVT   = 4;
   localparam int TG_ENA   = 6;
   localparam int TG_BEG   = 8;
   localparam int TG_FIN   = 16;
   localparam int CW_LEN   = 0;
   localparam int CW_POL   = 4;
   localparam int ST_GRP   = 1;
   // Reset values
   localparam logic [1:0]        CTRL_RST = 2'h0;
   localparam logic [BAUD_W-1:0] BAUD_RST = 11'h003;
   localparam logic [3:0]        PIN_RST  = 4'h0;
   localparam logic [11:0]       SYNC_RST = 12'h100;
   // Trigger source codes
   localparam logic [3:0] SRC_NONE = 4'h0;
   localparam logic [3:0] SRC_GIO0 = 4'h1;
   localparam logic [3:0] SRC_TMR0 = 4'h9;
   localparam logic [3:0] SRC_TICK = 4'hF;

   typedef enum logic [1:0] {
      EVT_RISE = 2'b00,
      EVT_FALL = 2'b01,
      EVT_LOW  = 2'b10,
      EVT_HIGH = 2'b11
   } mbsp_evt_e;

   typedef enum logic [1:0] {
      SQ_IDLE  = 2'b00,
      SQ_LOAD  = 2'b01,
      SQ_SHIFT = 2'b10,
      SQ_STORE = 2'b11
   } mbsp_seq_e;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic cs_n;
   } mbsp_pins_s;

   typedef struct packed {
      logic       cpol;
      logic [3:0] len_m1;
   } mbsp_fmt_s;

   typedef struct packed {
      logic [6:0] fin;
      logic [6:0] beg;
      logic       ena;
      mbsp_evt_e  evt;
      logic [3:0] src;
   } mbsp_tg_s;

   // Source code to trigger level
   function automatic logic trig_pick(input logic [3:0] src, input logic [7:0] gio,
                                      input logic [5:0] tmr, input logic tick);
      if (src == SRC_NONE)
         trig_pick = 1'b0;
      else if (src < SRC_TMR0)
         trig_pick = gio[3'(src - SRC_GIO0)];
      else if (src == SRC_TICK)
         trig_pick = tick;
      else
         trig_pick = tmr[3'(src - SRC_TMR0)];
   endfunction

   // Event qualification
   function automatic logic evt_hit(input mbsp_evt_e evt, input logic cur, input logic prv);
      case (evt)
         EVT_RISE: evt_hit = cur & ~prv;
         EVT_FALL: evt_hit = ~cur & prv;
         EVT_LOW:  evt_hit = ~cur;
         EVT_HIGH: evt_hit = cur;
         default:  evt_hit = 1'b0;
      endcase
   endfunction

   // Lowest pending group
   function automatic logic [2:0] first_set(input logic [NGRP-1:0] v);
      first_set = 3'h0;
      for (int i = NGRP - 1; i >= 0; i--) begin
         if (v[i])
            first_set = 3'(i);
      end
   endfunction
endpackage

// >>> logic/mbsp_sync.sv
// Module: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mbsp_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Levels in and filtered levels out
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] agree;
   logic [W-1:0] nxt_q;

   assign agree = ~(s2_ff ^ s3_ff);
   assign nxt_q = (agree & s3_ff) | (~agree & q_ff);
   assign q     = q_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
         q_ff  <= RST;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= nxt_q;
      end
   end
endmodule
`default_nettype wire

// >>> logic/mbsp_shift.sv
// Module: serial word shifter with baud divider, master or slave clocked
`timescale 1ns/1ps
`default_nettype none
module mbsp_shift (
   // Clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // Word request
   input  wire logic                        start,
   input  wire logic                        master,
   input  wire logic [mbsp_pkg::BAUD_W-1:0] baud,
   input  wire mbsp_pkg::mbsp_fmt_s         fmt,
   input  wire logic [mbsp_pkg::WORD_W-1:0] txd,
   output logic                             busy,
   output logic                             done,
   output logic [mbsp_pkg::WORD_W-1:0]      rxd,
   // Filtered serial lines in, driven serial lines out
   input  wire logic                        sclk_in,
   input  wire logic                        sdat_in,
   input  wire logic                        sel_n_in,
   output logic                             sclk_out,
   output logic                             sdat_out
);
   import mbsp_pkg::*;

   logic [WORD_W-1:0] sr_ff;
   logic [WORD_W-1:0] rxd_ff;
   logic [BAUD_W-1:0] cnt_ff;
   logic [3:0]        bits_ff;
   logic [3:0]        len_ff;
   logic              pol_ff;
   logic              run_ff;
   logic              sck_ff;
   logic              prv_ff;
   logic              smp_ff;
   logic              done_ff;
   logic              tgl;
   logic              sedge;
   logic              lead;
   logic              trail;
   logic              last;
   logic [3:0]        len_in;
   logic [WORD_W-1:0] shf;

   // Clock source: own divider or far clock
   assign tgl    = master & run_ff & (cnt_ff == baud); // RULE2 RULE3
   assign sedge  = ~master & run_ff & ~sel_n_in & (sclk_in != prv_ff); // RULE3
   assign lead   = (tgl & (sck_ff == pol_ff)) | (sedge & (sclk_in != pol_ff));
   assign trail  = (tgl | sedge) & ~lead;
   assign last   = trail & (bits_ff == len_ff);
   assign len_in = (fmt.len_m1 == 4'h0) ? 4'h1 : fmt.len_m1; // RULE1
   assign shf    = {sr_ff[WORD_W-2:0], smp_ff};

   assign busy     = run_ff;
   assign done     = done_ff;
   assign rxd      = rxd_ff;
   assign sclk_out = sck_ff;
   assign sdat_out = sr_ff[WORD_W-1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sr_ff   <= '0;
         rxd_ff  <= '0;
         cnt_ff  <= '0;
         bits_ff <= 4'h0;
         len_ff  <= 4'h1;
         pol_ff  <= 1'b0;
         run_ff  <= 1'b0;
         sck_ff  <= 1'b0;
         prv_ff  <= 1'b0;
         smp_ff  <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         prv_ff  <= sclk_in;
         done_ff <= last;
         cnt_ff  <= (tgl | ~run_ff) ? '0 : cnt_ff + 1'b1; // RULE2
         if (start) begin
            run_ff  <= 1'b1;
            bits_ff <= 4'h0;
            len_ff  <= len_in; // RULE4
            pol_ff  <= fmt.cpol; // RULE4
            sck_ff  <= fmt.cpol;
            sr_ff   <= txd << (4'hF - len_in); // RULE1
         end else begin
            if (tgl)
               sck_ff <= ~sck_ff;
            if (lead)
               smp_ff <= sdat_in;
            if (trail) begin
               sr_ff   <= shf;
               bits_ff <= bits_ff + 1'b1;
            end
            if (last) begin
               run_ff <= 1'b0;
               rxd_ff <= shf; // RULE1
            end
         end
      end
   end

   property p_baud;
      @(posedge hclk) disable iff (!hresetn)
      master && run_ff && !start && cnt_ff != baud |=> $stable(sck_ff);
   endproperty
   a_baud: assert property (p_baud) else $error("Serial clock moved early"); // RULE2

   property p_len;
      @(posedge hclk) disable iff (!hresetn)
      last && !start |=> done_ff && !run_ff && rxd_ff == $past(shf);
   endproperty
   a_len: assert property (p_len) else $error("Word did not end on its last bit"); // RULE1
endmodule
`default_nettype wire

// >>> verification/mbsp_peer.sv
// Serial peripheral model: answers a set word, records what it hears
`timescale 1ns/1ps
`default_nettype none
module mbsp_peer (
   // Serial pads
   input  wire logic        sclk,
   input  wire logic        mosi,
   input  wire logic        cs_n,
   output logic             miso,
   // Setup
   input  wire logic        cpol,
   input  wire logic [15:0] reply
);
   logic [15:0] sh;
   logic [15:0] got [2];
   int          cnt [2];
   int          n;
   int          idx;
   time         t_last = 0;
   time         half = 0;
   initial miso = 1'b0;
   always @(negedge cs_n) begin
      sh = 16'h0000;
      n = 0;
      idx = 15;
      miso = reply[15];
   end
   always @(sclk) begin
      if (cs_n === 1'b0) begin
         half = $time - t_last;
         t_last = $time;
         if (sclk != cpol) begin
            sh = {sh[14:0], mosi};
            n++;
         end else if (idx > 0) begin
            idx--;
            miso = reply[idx];
         end
      end
   end
   // Deselected: inverse of last value
   always @(posedge cs_n) begin
      got[0] = got[1];
      got[1] = sh;
      cnt[0] = cnt[1];
      cnt[1] = n;
      miso = ~miso;
   end
endmodule
`default_nettype wire

// >>> verification/multibuffer_spi_trigger_select_bench.sv
// Bench: registers, pin use, trigger decode, a master transfer and a slave transfer
`timescale 1ns/1ps
`default_nettype none
module multibuffer_spi_trigger_select_bench;
   import mbsp_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [14:0] trg = 15'h0000;
   logic [3:0]  ext = 4'h1;
   logic [15:0] reply = 16'h0000;
   logic        miso;
   mbsp_pins_s  pdrv;
   mbsp_pins_s  poe;
   mbsp_pins_s  pad;
   int          errors = 0;
   int          checks_done = 0;
   logic [31:0] q;
   logic [31:0] t0;
   logic [31:0] t1;
   logic [3:0]  r;
   always #10 hclk = ~hclk;
   assign pad.sclk = poe.sclk ? pdrv.sclk : ext[3];
   assign pad.mosi = poe.mosi ? pdrv.mosi : ext[2];
   assign pad.miso = poe.miso ? pdrv.miso : miso;
   assign pad.cs_n = poe.cs_n ? pdrv.cs_n : ext[0];
   mbsp_top i_mbsp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .general_io_port_a(trg[7:0]), .high_end_timer_channel(trg[13:8]),
      .tick_count(trg[14]), .pin_level(pad), .pin_drive(pdrv), .pin_oe(poe));
   mbsp_peer i_mbsp_peer (.sclk(pad.sclk), .mosi(pad.mosi), .cs_n(pad.cs_n), .miso(miso),
      .cpol(1'b0), .reply(reply));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic rst();
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
   endtask
   function automatic logic [31:0] tgw(input int s, input logic [1:0] e, input int b, input int f);
      tgw = (32'(s) << TG_SRC) | (32'(e) << TG_EVT) | (32'h0000_0001 << TG_ENA);
      tgw = tgw | (32'(b) << TG_BEG) | (32'(f) << TG_FIN);
   endfunction
   task automatic give_verdict();
      $display("Counts: %0d checks, %0d errors", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #1_500_000;
      errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'ha051));
      rst();
      rc(OFS_BAUD, 32'(BAUD_RST));
      rc(12'h01C, 32'h0000_0000);
      t0 = $urandom();
      wr(12'h7F8, t0);
      rc(12'h7F8, t0);
      t1 = $urandom() & 32'h0000_07FF;
      wr(OFS_BAUD, t1);
      rc(OFS_BAUD, t1);
      $display("Test registers done");
      r = 4'($urandom());
      wr(OFS_GDIR, 32'(r));
      wr(OFS_GOUT, t0);
      @(posedge hclk);
      ext <= t0[7:4];
      repeat (6) @(negedge hclk);
      chk(32'(poe), 32'(r));
      chk(32'(4'(pdrv) & r), 32'(t0[3:0] & r));
      t1 = 32'((r & t0[3:0]) | (~r & {ext[3:2], miso, ext[0]}));
      rc(OFS_GIN, t1);
      $display("Test pins done");
      for (int c = 0; c < 16; c++) begin
         logic [14:0] m;
         logic [14:0] idle;
         m = (c == 0) ? 15'h0000 : 15'h0001 << (c - 1);
         idle = c[0] ? 15'h0000 : 15'h7FFF;
         trg <= idle;
         rst();
         wr(OFS_TG, tgw(c, c[0] ? EVT_RISE : EVT_LOW, 0, 0));
         @(posedge hclk);
         trg <= idle ^ ~m;
         repeat (6) @(posedge hclk);
         bus(1'b0, OFS_STAT, 32'h0000_0000);
         chk(q & 32'h0000_00FF, 32'h0000_0000);
         @(posedge hclk);
         trg <= ~idle;
         repeat (6) @(posedge hclk);
         bus(1'b0, OFS_STAT, 32'h0000_0000);
         chk(q & 32'h0000_00FF, 32'(m != 15'h0000));
      end
      $display("Test triggers done");
      trg <= 15'h0000;
      ext <= 4'h1;
      rst();
      reply <= 16'($urandom());
      wr(OFS_BAUD, 32'h0000_0004);
      wr(OFS_PFUN, 32'h0000_000F);
      wr(OFS_RAM, {16'h0001, t0[15:0]});
      wr(OFS_RAM + 12'h008, {16'h000F, t0[31:16]});
      wr(OFS_TG, tgw(SRC_GIO0, EVT_RISE, 0, 1));
      wr(OFS_CTRL, 32'h0000_0003);
      @(posedge hclk);
      trg <= 15'h0001;
      q = 32'h0000_0000;
      for (int i = 0; i < 300 && q[16] !== 1'b1; i++)
         bus(1'b0, OFS_RAM + 12'h00C, 32'h0000_0000);
      chk(q, {16'h0001, reply});
      rc(OFS_RAM + 12'h004, {16'h0001, 14'h0000, reply[15:14]});
      chk(32'(i_mbsp_peer.got[0]), 32'(t0[1:0]));
      chk(32'(i_mbsp_peer.got[1]), 32'(t0[31:16]));
      chk(32'(i_mbsp_peer.cnt[0]), 32'h0000_0002);
      chk(32'(i_mbsp_peer.cnt[1]), 32'h0000_0010);
      chk(32'(i_mbsp_peer.half), 32'h0000_0064);
      wr(OFS_RAM + 12'h00C, t0);
      rc(OFS_RAM + 12'h00C, {16'h0001, reply});
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_RAM + 12'h010, {16'h0001, 16'h0000});
      wr(OFS_TG, tgw(SRC_TICK, EVT_RISE, 2, 2));
      @(posedge hclk);
      trg <= 15'h4001;
      for (int b = 1; b >= 0; b--) begin
         ext <= {1'b0, r[b], 2'b00};
         repeat (6) @(posedge hclk);
         ext[3] <= 1'b1;
         repeat (6) @(posedge hclk);
      end
      ext[3] <= 1'b0;
      repeat (9) @(posedge hclk);
      ext <= 4'h1;
      rc(OFS_RAM + 12'h014, {16'h0011, 14'h0000, r[1:0]});
      $display("Test transfer done");
      give_verdict();
   end
endmodule
`default_nettype wire
